// *** sasp_serial_port.sv ***
// mode 1 serial slave port of a 16-bit sensor converter
// assumes converter results arrive on ref_clk with a one-cycle strobe
`timescale 1ns/1ps
`default_nettype none
module sasp_serial_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // serial pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  output logic serial_out_ready_line,
  output logic serial_out_ready_line_oe,
  output logic conversion_ready_n,
  // configuration
  input wire logic ready_on_output_select,
  input wire logic temp_sensor_select,
  // converter side
  input wire logic [15:0] conv_result,
  input wire logic conv_done,
  output logic temp_mode
);

  // ----------------------------------------------------------------
  // pin conditioning
  // ----------------------------------------------------------------
  sasp_link_if lnk ();

  sasp_pin_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .sclk(sclk),
    .din(din),
    .lnk(lnk)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sasp_pkg::sasp_core_st_t q;
  sasp_pkg::sasp_core_st_t d;
  logic [7:0] cmd_next;

  assign cmd_next = {q.cmd[6:0], lnk.din_s};

  always_comb
  begin
    d = q;
    // conversion source follows the select bit
    d.temp_mode = temp_sensor_select;
    // raw code kept as delivered
    if (conv_done)
      d.hold = conv_result;
    if (!lnk.cs_act)
    begin
      d.cmd_cnt = 3'h0;
      d.launched = 1'b0;
      d.rd_arm = 1'b0;
      d.out_bit = 1'b1;
      d.st = sasp_pkg::SH_IDLE;
      d.sh_cnt = 4'h0;
    end
    else
    begin
      if (lnk.sclk_rise)
      begin
        // data changes only on rising edges
        d.launched = 1'b1;
        case (q.st)
          sasp_pkg::SH_IDLE:
          begin
            if (q.new_data || q.rd_arm)
            begin
              // snapshot of latest result, msb first
              d.out_bit = q.hold[sasp_pkg::RES_W-1];
              d.sh = {q.hold[14:0], 1'b1};
              d.sh_cnt = sasp_pkg::SH_LAST;
              d.st = sasp_pkg::SH_SHIFT;
              d.rd_arm = 1'b0;
              d.new_data = 1'b0;
              d.cmd_cnt = 3'h0;
            end
            else
            begin
              d.out_bit = 1'b1;
            end
          end
          sasp_pkg::SH_SHIFT:
          begin
            if (q.sh_cnt != 4'h0)
            begin
              d.out_bit = q.sh[sasp_pkg::RES_W-1];
              d.sh = {q.sh[14:0], 1'b1};
              d.sh_cnt = q.sh_cnt - 4'h1;
            end
          end
          default:
          begin
            d.st = sasp_pkg::SH_IDLE;
          end
        endcase
      end
      if (lnk.sclk_fall)
      begin
        // sample on falling edges
        if (q.st == sasp_pkg::SH_SHIFT)
        begin
          // readout in progress, commands ignored
          if (q.sh_cnt == 4'h0)
            d.st = sasp_pkg::SH_IDLE;
        end
        else
        begin
          d.cmd = cmd_next;
          d.cmd_cnt = q.cmd_cnt + 3'h1;
          if (q.cmd_cnt == sasp_pkg::CMD_LAST)
          begin
            d.cmd_cnt = 3'h0;
            // read command arms a readout only while no readout is in progress
            if (cmd_next == sasp_pkg::CMD_READ_RESULT)
              d.rd_arm = 1'b1;
          end
        end
      end
    end
    // a new result wins over a clear in the same cycle
    if (conv_done)
      d.new_data = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= sasp_pkg::CORE_RST;
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // released while deselected
  assign serial_out_ready_line_oe = lnk.cs_act;
  // poll level before first launch edge
  assign serial_out_ready_line =
    (!q.launched && ready_on_output_select) ? ~q.new_data : q.out_bit;
  // always driven
  assign conversion_ready_n = ~q.new_data;
  assign temp_mode = q.temp_mode;

endmodule
`default_nettype wire

// *** sasp_pkg.sv ***
// constants and types of the sensor converter serial port
// assumes a single 250 MHz ref_clk domain
`default_nettype none
package sasp_pkg;

  // ----------------------------------------------------------------
  // sizes and codes
  // ----------------------------------------------------------------
  localparam int RES_W = 16;
  localparam int CMD_W = 8;
  localparam int POLL_FLUSH_CLKS = 16;
  localparam logic [7:0] CMD_READ_RESULT = 8'h10;
  localparam logic [15:0] RES_RST = 16'h0000;
  localparam logic [3:0] SH_LAST = 4'hf;
  localparam logic [2:0] CMD_LAST = 3'h7;

  // ----------------------------------------------------------------
  // pin synchroniser state, bit order {cs_n, sclk, din}
  // ----------------------------------------------------------------
  localparam int PIN_CS = 2;
  localparam int PIN_SCLK = 1;
  localparam int PIN_DIN = 0;

  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] sync;
    logic sclk_prev;
  } sasp_sync_st_t;

  localparam sasp_sync_st_t SYNC_RST = '{
    meta: 3'h4, sync: 3'h4, sclk_prev: 1'b0};

  // ----------------------------------------------------------------
  // core state
  // ----------------------------------------------------------------
  typedef enum logic {SH_IDLE, SH_SHIFT} sasp_shift_t;

  typedef struct packed {
    logic [15:0] hold;
    logic new_data;
    logic [15:0] sh;
    logic [3:0] sh_cnt;
    sasp_shift_t st;
    logic [7:0] cmd;
    logic [2:0] cmd_cnt;
    logic rd_arm;
    logic launched;
    logic out_bit;
    logic temp_mode;
  } sasp_core_st_t;

  localparam sasp_core_st_t CORE_RST = '{
    hold: RES_RST, new_data: 1'b0, sh: 16'hffff, sh_cnt: 4'h0,
    st: SH_IDLE, cmd: 8'h00, cmd_cnt: 3'h0, rd_arm: 1'b0,
    launched: 1'b0, out_bit: 1'b1, temp_mode: 1'b0};

endpackage
`default_nettype wire

// *** sasp_link_if.sv ***
// conditioned link events between pin synchroniser and core
// assumes both ends run on ref_clk
`timescale 1ns/1ps
`default_nettype none
interface sasp_link_if;
  logic cs_act;
  logic sclk_rise;
  logic sclk_fall;
  logic din_s;
  modport src (output cs_act, output sclk_rise, output sclk_fall,
    output din_s);
  modport dst (input cs_act, input sclk_rise, input sclk_fall,
    input din_s);
endinterface
`default_nettype wire

// *** sasp_pin_sync.sv ***
// two-stage synchroniser and edge finder for the serial pins
// assumes pins are asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module sasp_pin_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // raw pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic din,
  // conditioned events
  sasp_link_if.src lnk
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sasp_pkg::sasp_sync_st_t q;
  sasp_pkg::sasp_sync_st_t d;

  always_comb
  begin
    d = q;
    d.meta = {cs_n, sclk, din};
    d.sync = q.meta;
    d.sclk_prev = q.sync[sasp_pkg::PIN_SCLK];
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= sasp_pkg::SYNC_RST;
    else
      q <= d;
  end

  // ----------------------------------------------------------------
  // events, only while selected
  // ----------------------------------------------------------------
  assign lnk.cs_act = ~q.sync[sasp_pkg::PIN_CS];
  // launch edge
  assign lnk.sclk_rise = lnk.cs_act & q.sync[sasp_pkg::PIN_SCLK]
    & ~q.sclk_prev;
  // sample edge
  assign lnk.sclk_fall = lnk.cs_act & ~q.sync[sasp_pkg::PIN_SCLK]
    & q.sclk_prev;
  assign lnk.din_s = q.sync[sasp_pkg::PIN_DIN];

endmodule
`default_nettype wire

// *** sasp_serial_port_props.sv ***
// assertions on the serial port pins
// assumes one ref_clk domain
`timescale 1ns/1ps
`default_nettype none
module sasp_serial_port_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // pins
  input wire logic cs_n,
  input wire logic serial_out_ready_line,
  input wire logic serial_out_ready_line_oe,
  input wire logic conversion_ready_n,
  // config and converter
  input wire logic ready_on_output_select,
  input wire logic temp_sensor_select,
  input wire logic conv_done,
  input wire logic temp_mode
);
  wire lo = serial_out_ready_line;
  wire oe = serial_out_ready_line_oe;
  wire rn = conversion_ready_n;
  wire s1 = ready_on_output_select;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_float_off: assert property (cs_n [*4] |-> !oe)
    else $error("line driven while off");
  chk_drive_sel: assert property ((!cs_n) [*4] |-> oe)
    else $error("line not driven");
  chk_ready_set: assert property (conv_done |=> !rn)
    else $error("ready pin late");
  chk_ready_cause: assert property ($fell(rn) |-> $past(conv_done))
    else $error("ready without result");
  chk_ready_kept: assert property (cs_n [*4] ##0 !rn |=> !rn)
    else $error("ready lost while off");
  chk_poll_level: assert property ($rose(oe) && s1 |-> lo == rn)
    else $error("poll level wrong");
  chk_pin_only: assert property ($rose(oe) && !s1 |-> lo)
    else $error("ready on line");
  chk_clear_sel: assert property ($rose(rn) |-> !cs_n)
    else $error("ready cleared while off");
  chk_temp_copy: assert property (1'b1 |=>
    temp_mode == $past(temp_sensor_select))
    else $error("temp mode wrong");
  cover property ($rose(oe) && !rn);
  cover property ($rose(rn));
  cover property ($rose(temp_mode));
endmodule
bind sasp_serial_port sasp_serial_port_props i_sasp_serial_port_props (
  .ref_clk, .rst_n, .cs_n, .serial_out_ready_line,
  .serial_out_ready_line_oe, .conversion_ready_n,
  .ready_on_output_select, .temp_sensor_select, .conv_done,
  .temp_mode);
`default_nettype wire

// *** sasp_host_model.sv ***
// host master model of the serial link
// assumes the port floats its line when deselected
`timescale 1ns/1ps
`default_nettype none
module sasp_host_model (
  // shared line from the port
  input wire logic line_val,
  input wire logic line_oe,
  // host pins
  output var logic cs_n,
  output var logic sclk,
  output var logic din
);
  logic last = 1'b1;
  logic line;
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  always @(line_val, line_oe)
    if (line_oe)
      last = line_val;
  assign line = line_oe ? line_val : ~last;
  // one frame: n bits of tx msb first, line read on falls
  task automatic frame(input int n, input logic [31:0] tx,
    output logic [31:0] rx, output logic poll);
    rx = 32'h0000_0000;
    cs_n = 1'b0;
    #36;
    poll = line;
    for (int i = 0; i < n; i++)
    begin
      sclk = 1'b1;
      din = tx[31 - i];
      #40;
      sclk = 1'b0;
      rx = {rx[30:0], line};
      #40;
    end
    cs_n = 1'b1;
    din = ~din;
    #40;
  endtask
endmodule
`default_nettype wire

// *** sasp_serial_port_tb.sv ***
// self-checking bench of the serial port
// assumes the host model and the props checker
`timescale 1ns/1ps
`default_nettype none
module sasp_serial_port_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b1;
  logic tss = 1'b0;
  logic done = 1'b0;
  logic [15:0] res = 16'h0000;
  logic cs_n, sclk, din, lo, oe, rn, tm, poll;
  logic [31:0] rx;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  always #2 ref_clk = ~ref_clk;
  sasp_serial_port i_sasp_serial_port (.ref_clk, .rst_n, .cs_n,
    .sclk, .din, .serial_out_ready_line(lo),
    .serial_out_ready_line_oe(oe), .conversion_ready_n(rn),
    .ready_on_output_select(sel), .temp_sensor_select(tss),
    .conv_result(res), .conv_done(done), .temp_mode(tm));
  sasp_host_model i_sasp_host_model (.line_val(lo), .line_oe(oe),
    .cs_n, .sclk, .din);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic push(input logic [15:0] v);
    @(negedge ref_clk);
    res = v;
    done = 1'b1;
    @(negedge ref_clk);
    done = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic t_poll;
    i_sasp_host_model.frame(0, 32'h0000_0000, rx, poll);
    check(poll, 1'b1);
    push(16'h1234);
    push(16'ha5c3);
    check(rn, 1'b0);
    i_sasp_host_model.frame(32, 32'h0000_0000, rx, poll);
    check(poll, 1'b0);
    check(rx, 32'ha5c3_ffff);
    check(rn, 1'b1);
    $display("poll test done");
  endtask
  task automatic t_cmd;
    @(negedge ref_clk);
    sel = 1'b0;
    // a second read code inside the readout must not arm another one
    i_sasp_host_model.frame(32, {sasp_pkg::CMD_READ_RESULT,
      sasp_pkg::CMD_READ_RESULT, 16'h0000}, rx, poll);
    check(poll, 1'b1);
    check(rx, 32'hffa5_c3ff);
    $display("command test done");
  endtask
  task automatic t_temp;
    push(16'h0f0f);
    i_sasp_host_model.frame(0, 32'h0000_0000, rx, poll);
    check({poll, rn}, 2'b10);
    i_sasp_host_model.frame(32, 32'h0000_0000, rx, poll);
    check(rx, 32'h0f0f_ffff);
    tss = 1'b1;
    repeat (2) @(negedge ref_clk);
    check(tm, 1'b1);
    push(16'h0c80);
    i_sasp_host_model.frame(32, 32'h0000_0000, rx, poll);
    check(rx, 32'h0c80_ffff);
    $display("temp test done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    check({oe, rn, tm}, 3'b010);
    t_poll;
    t_cmd;
    t_temp;
    give_verdict;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      give_verdict;
    end
  end
endmodule
`default_nettype wire
